// *** src/see_eeprom_client.sv ***
`timescale 1ns/1ps
// What this block does
// - Data may change only while the clock is low, and a change while it is high is a start or stop.
// - A falling data line while the clock is high is a start, and the host starts every command so.
// - A rising data line while the clock is high is a stop, which ends every sequence.
// - A stop that ends a read sends the device to standby.
// - Words are eight bits; each received word but a refused address or a data word meeting a full buffer is acknowledged by pulling data low on the ninth clock.
// - The device is in standby after reset and after a stop once all internal work is done.
// - The main array is 512 pages of 64 bytes, chosen by the memory device-type code.
// - Security sector access needs word address bits 10:9 at 00, with bits 5:0 picking the byte.
// - Unique-ID access needs word address bits 10:9 at 01, with bits 3:0 picking the byte.
// - A byte, page or security-sector write or a sector lock starts an internal write cycle.
// - When sending, the data output changes only a fixed hold time after the clock falls.
// - The address byte carries 1010 for the array or 1011 for special areas, chip selects, then read bit.
// - While a write cycle runs, inputs are ignored and no acknowledge is given.
// - A non-matching address gets no acknowledge and the device waits in standby for the next start.
module see_eeprom_client import see_pkg::*; (
  input  wire logic                  ref_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_o,
  input  wire logic                  chip_select_bit2_i,
  input  wire logic                  chip_select_bit1_i,
  input  wire logic                  chip_select_bit0_i,
  input  wire logic                  wr_busy_i,
  output logic                       wcyc_start_o,
  output logic                       standby_o,
  output logic [SEE_ADDR_W-1:0]      word_addr_o,
  output see_area_type               area_o,
  output logic                       wr_valid_o,
  input  wire logic                  wr_ready_i,
  output logic [7:0]                 wr_data_o,
  output logic [SEE_ADDR_W-1:0]      wr_addr_o,
  output see_area_type               wr_area_o,
  output logic                       rd_ready_o,
  input  wire logic                  rd_valid_i,
  input  wire logic [7:0]            rd_data_i
);

  logic [4:0]           pins_s;
  logic                 scl_s;
  logic                 sda_s;
  logic [2:0]           cs_s;
  logic                 scl_d_r;
  logic                 sda_d_r;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  see_state_type        state_r;
  see_state_type        state_nxt;
  logic [3:0]           bit_cnt_r;
  logic [3:0]           cnt_after_fall;
  logic [7:0]           rx_shift_r;
  logic [7:0]           tx_shift_r;
  logic                 tx_need_r;
  logic [15:0]          addr_r;
  logic                 spec_r;
  logic                 wr_any_r;
  logic                 rx_state;
  logic                 byte_done;
  logic                 dev_match;
  logic                 ack_ok;
  logic                 drv_low_nxt;
  logic                 drv_pend_r;
  logic [4:0]           hold_cnt_r;
  logic                 sda_oe_r;
  logic                 wcyc_start_r;
  logic                 standby_r;
  logic [SEE_ADDR_W-1:0] word_addr_r;
  see_area_type         area_r;
  see_area_type         area_c;
  logic [SEE_ADDR_W-1:0] addr_c;
  logic                 host_ack_rise;
  logic                 buf_in_ready;
  logic                 buf_push;
  logic                 rd_take;
  logic [SEE_WORD_W-1:0] buf_out;

  // Pins cross into the clock domain through two flops
  see_sync #(
    .WIDTH (5)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i, sda_i, scl_i}),
    .sync_o    (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign cs_s  = pins_s[4:2];

  // Previous synchronised levels for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Clock edges and data changes while the clock is high
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Receiving states and end of a received word
  assign rx_state  = (state_r == SEE_ST_DEV) || (state_r == SEE_ST_ADR_HI) ||
                     (state_r == SEE_ST_ADR_LO) || (state_r == SEE_ST_WR_DATA);
  assign byte_done = scl_fall & rx_state & (bit_cnt_r == SEE_DATA_BITS);
  assign cnt_after_fall = (bit_cnt_r == SEE_ACK_CLOCK) ? SEE_CNT_ZERO : bit_cnt_r;
  assign host_ack_rise  = scl_rise & (state_r == SEE_ST_RD_DATA) &
                          (bit_cnt_r == SEE_DATA_BITS) & !sda_oe_r;  // Not our own address ack

  // Device code, chip selects and idle write engine must all agree
  assign dev_match = ((rx_shift_r[SEE_CODE_HI:SEE_CODE_LO] == SEE_CODE_MAIN) ||
                      (rx_shift_r[SEE_CODE_HI:SEE_CODE_LO] == SEE_CODE_SPEC)) &&
                     (rx_shift_r[SEE_CS_HI:SEE_CS_LO] == cs_s) && !wr_busy_i;

  // Acknowledge decision for the word just received
  always_comb begin
    ack_ok = 1'b0;
    unique case (state_r)
      SEE_ST_DEV:     ack_ok = dev_match;
      SEE_ST_ADR_HI:  ack_ok = 1'b1;
      SEE_ST_ADR_LO:  ack_ok = 1'b1;
      SEE_ST_WR_DATA: ack_ok = buf_in_ready;  // Full buffer refuses the word
      default:        ack_ok = 1'b0;
    endcase
  end

  // Next state at each word boundary
  always_comb begin
    state_nxt = state_r;
    if (byte_done) begin
      unique case (state_r)
        SEE_ST_DEV: begin
          if (!dev_match) begin
            state_nxt = SEE_ST_IGNORE;
          end else if (rx_shift_r[SEE_RW_BIT]) begin
            state_nxt = SEE_ST_RD_DATA;
          end else begin
            state_nxt = SEE_ST_ADR_HI;
          end
        end
        SEE_ST_ADR_HI:  state_nxt = SEE_ST_ADR_LO;
        SEE_ST_ADR_LO:  state_nxt = SEE_ST_WR_DATA;
        default:        state_nxt = state_r;
      endcase
    end else if (host_ack_rise && sda_s) begin
      state_nxt = SEE_ST_IGNORE;  // Host ends the read with no acknowledge
    end
  end

  // Bus state: stop beats start beats bit traffic
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_r <= SEE_ST_STANDBY;
    end else if (stop_det) begin
      state_r <= SEE_ST_STANDBY;
    end else if (start_det) begin
      state_r <= SEE_ST_DEV;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Clock count within a nine-clock frame
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || start_det || stop_det) begin
      bit_cnt_r <= SEE_CNT_ZERO;
    end else if (scl_rise && (rx_state || state_r == SEE_ST_RD_DATA) &&
                 bit_cnt_r != SEE_ACK_CLOCK) begin
      bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
    end else if (scl_fall) begin
      bit_cnt_r <= cnt_after_fall;
    end
  end

  // Data sampled on rising clock, msb first
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_shift_r <= 8'h00;
    end else if (scl_rise && rx_state && bit_cnt_r < SEE_DATA_BITS) begin
      rx_shift_r <= {rx_shift_r[6:0], sda_s};
    end
  end

  // Device-code type and word address
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      spec_r <= 1'b0;
      addr_r <= SEE_ADDR_RST;
    end else if (byte_done && state_r == SEE_ST_DEV && dev_match) begin
      spec_r <= (rx_shift_r[SEE_CODE_HI:SEE_CODE_LO] == SEE_CODE_SPEC);
    end else if (byte_done && state_r == SEE_ST_ADR_HI) begin
      addr_r[15:8] <= rx_shift_r;
    end else if (byte_done && state_r == SEE_ST_ADR_LO) begin
      addr_r[7:0] <= rx_shift_r;
    end else if (buf_push) begin
      // Writes wrap inside the page
      addr_r[SEE_PAGE_OFS_W-1:0] <= SEE_PAGE_OFS_W'(addr_r[SEE_PAGE_OFS_W-1:0] + 1'b1);
    end else if (rd_take) begin
      addr_r[SEE_ADDR_W-1:0] <= SEE_ADDR_W'(addr_r[SEE_ADDR_W-1:0] + 1'b1);
    end
  end

  // Area select and masked byte address
  always_comb begin
    area_c = SEE_AREA_MAIN;
    addr_c = addr_r[SEE_ADDR_W-1:0];
    if (spec_r) begin
      unique case (addr_r[SEE_SEL_HI:SEE_SEL_LO])
        SEE_SEL_SEC: begin
          area_c = SEE_AREA_SEC;
          addr_c = SEE_ADDR_W'(addr_r[SEE_SEC_OFS_W-1:0]);
        end
        SEE_SEL_UID: begin
          area_c = SEE_AREA_UID;
          addr_c = SEE_ADDR_W'(addr_r[SEE_UID_OFS_W-1:0]);
        end
        SEE_SEL_LOCK: begin
          area_c = SEE_AREA_LOCK;
          addr_c = '0;
        end
        default: begin
          area_c = SEE_AREA_LOCK;
          addr_c = '0;
        end
      endcase
    end
  end

  // Registered address outputs
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      word_addr_r <= '0;
      area_r      <= SEE_AREA_MAIN;
    end else begin
      word_addr_r <= addr_c;
      area_r      <= area_c;
    end
  end

  // Received data words go to the write buffer
  assign buf_push = byte_done && (state_r == SEE_ST_WR_DATA) && buf_in_ready;

  see_buf2 #(
    .WIDTH (SEE_WORD_W)
  ) u_buf (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({area_c, addr_c, rx_shift_r}),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (buf_out)
  );

  assign wr_data_o = buf_out[7:0];
  assign wr_addr_o = buf_out[SEE_ADDR_W+7:8];
  assign wr_area_o = see_area_type'(buf_out[SEE_WORD_W-1:SEE_ADDR_W+8]);

  // Write sequence bookkeeping and write cycle launch at stop
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_any_r     <= 1'b0;
      wcyc_start_r <= 1'b0;
    end else begin
      wcyc_start_r <= stop_det && wr_any_r && (state_r == SEE_ST_WR_DATA) &&
                      (bit_cnt_r <= 4'(SEE_CNT_ZERO + 4'h1));
      if (stop_det || start_det) begin
        wr_any_r <= 1'b0;
      end else if (buf_push) begin
        wr_any_r <= 1'b1;
      end
    end
  end

  // Transmit word fetch: request after address or host acknowledge
  assign rd_take = rd_valid_i & tx_need_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tx_need_r  <= 1'b0;
      tx_shift_r <= 8'hff;
    end else if (start_det || stop_det) begin
      tx_need_r <= 1'b0;
    end else if (rd_take) begin
      tx_shift_r <= rd_data_i;
      tx_need_r  <= 1'b0;
    end else if (byte_done && state_r == SEE_ST_DEV && dev_match &&
                 rx_shift_r[SEE_RW_BIT]) begin
      tx_need_r <= 1'b1;
    end else if (host_ack_rise && !sda_s) begin
      tx_need_r <= 1'b1;
    end
  end

  // Level to drive after the coming clock fall
  always_comb begin
    drv_low_nxt = 1'b0;
    if (state_r == SEE_ST_RD_DATA && cnt_after_fall < SEE_DATA_BITS && !tx_need_r) begin
      drv_low_nxt = ~tx_shift_r[3'(4'h7 - cnt_after_fall)];
    end else if (byte_done) begin
      drv_low_nxt = ack_ok;
    end
  end

  // Data output changes a hold time after the clock falls
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || start_det || stop_det) begin
      hold_cnt_r <= SEE_HOLD_IDLE;
      drv_pend_r <= 1'b0;
      sda_oe_r   <= 1'b0;
    end else if (scl_fall) begin
      hold_cnt_r <= SEE_HOLD_LOAD;
      drv_pend_r <= drv_low_nxt;
    end else if (hold_cnt_r == SEE_HOLD_LAST) begin
      hold_cnt_r <= SEE_HOLD_IDLE;
      sda_oe_r   <= drv_pend_r;
    end else if (hold_cnt_r != SEE_HOLD_IDLE) begin
      hold_cnt_r <= 5'(hold_cnt_r - 5'h01);
    end
  end

  // Standby when idle and no write cycle running
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= ((state_r == SEE_ST_STANDBY) || (state_r == SEE_ST_IGNORE)) &&
                   !wr_busy_i;
    end
  end

  assign sda_o        = 1'b0;  // Open drain: only ever pulls low
  assign sda_oe_o     = sda_oe_r;
  assign wcyc_start_o = wcyc_start_r;
  assign standby_o    = standby_r;
  assign word_addr_o  = word_addr_r;
  assign area_o       = area_r;
  assign rd_ready_o   = tx_need_r;

endmodule

// *** src/see_pkg.sv ***
package see_pkg;

  // Device address byte layout
  localparam logic [3:0] SEE_CODE_MAIN   = 4'ha;
  localparam logic [3:0] SEE_CODE_SPEC   = 4'hb;
  localparam int         SEE_CODE_HI     = 7;
  localparam int         SEE_CODE_LO     = 4;
  localparam int         SEE_CS_HI       = 3;
  localparam int         SEE_CS_LO       = 1;
  localparam int         SEE_RW_BIT      = 0;

  // Framing counts
  localparam logic [3:0] SEE_DATA_BITS   = 4'h8;
  localparam logic [3:0] SEE_ACK_CLOCK   = 4'h9;
  localparam logic [3:0] SEE_CNT_ZERO    = 4'h0;

  // Word address layout
  localparam int         SEE_ADDR_W      = 15;
  localparam int         SEE_PAGE_OFS_W  = 6;
  localparam int         SEE_SEL_HI      = 10;
  localparam int         SEE_SEL_LO      = 9;
  localparam int         SEE_SEC_OFS_W   = 6;
  localparam int         SEE_UID_OFS_W   = 4;
  localparam logic [1:0] SEE_SEL_SEC     = 2'h0;
  localparam logic [1:0] SEE_SEL_UID     = 2'h1;
  localparam logic [1:0] SEE_SEL_LOCK    = 2'h2;
  localparam logic [15:0] SEE_ADDR_RST   = 16'h0000;

  // Output hold after clock fall, in ns, and its cycle count at 200 MHz
  localparam int         SEE_CLK_MHZ     = 200;
  localparam int         SEE_TX_HOLD_NS  = 100;
  localparam int         SEE_HOLD_CYC    = (SEE_TX_HOLD_NS * SEE_CLK_MHZ + 999) / 1000;
  localparam logic [4:0] SEE_HOLD_LOAD   = 5'(SEE_HOLD_CYC);
  localparam logic [4:0] SEE_HOLD_LAST   = 5'h01;
  localparam logic [4:0] SEE_HOLD_IDLE   = 5'h00;

  // Selected storage area
  typedef enum logic [1:0] {
    SEE_AREA_MAIN = 2'h0,
    SEE_AREA_SEC  = 2'h1,
    SEE_AREA_UID  = 2'h2,
    SEE_AREA_LOCK = 2'h3
  } see_area_type;

  // Bus state machine, Gray coded along the usual path
  typedef enum logic [2:0] {
    SEE_ST_STANDBY = 3'h0,
    SEE_ST_DEV     = 3'h1,
    SEE_ST_ADR_HI  = 3'h3,
    SEE_ST_ADR_LO  = 3'h2,
    SEE_ST_WR_DATA = 3'h6,
    SEE_ST_RD_DATA = 3'h7,
    SEE_ST_IGNORE  = 3'h5
  } see_state_type;

  // Buffered write word: area, address, data
  localparam int         SEE_WORD_W      = 2 + SEE_ADDR_W + 8;

endpackage

// *** src/see_sync.sv ***
`timescale 1ns/1ps
module see_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Two flops per bit; idle bus level is high
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// *** src/see_buf2.sv ***
`timescale 1ns/1ps
module see_buf2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem_r [2];
  logic             wr_ptr_r;
  logic             rd_ptr_r;
  logic [1:0]       count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem_r[rd_ptr_r];

  // Storage, written by index
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      count_r <= 2'(count_r + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule

// *** sim/see_chk_props.sv ***
`timescale 1ns/1ps
module see_chk import see_pkg::*; (
  input wire logic                  ref_clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  scl_i,
  input wire logic                  sda_i,
  input wire logic                  sda_o,
  input wire logic                  sda_oe_o,
  input wire logic                  chip_select_bit2_i,
  input wire logic                  chip_select_bit1_i,
  input wire logic                  chip_select_bit0_i,
  input wire logic                  wr_busy_i,
  input wire logic                  wcyc_start_o,
  input wire logic                  standby_o,
  input wire logic [SEE_ADDR_W-1:0] word_addr_o,
  input wire see_area_type          area_o,
  input wire logic                  wr_valid_o,
  input wire logic                  wr_ready_i,
  input wire logic [7:0]            wr_data_o,
  input wire logic [SEE_ADDR_W-1:0] wr_addr_o,
  input wire see_area_type          wr_area_o,
  input wire logic                  rd_ready_o,
  input wire logic                  rd_valid_i,
  input wire logic [7:0]            rd_data_i
);
  logic       scl_r, sda_r, rd_r, first_r, start_ev, stop_ev;
  logic [4:0] low_r, stop_r;
  logic [3:0] bit_r;

  // Bus conditions seen at the pins
  assign start_ev = scl_i && scl_r && sda_r && !sda_i;
  assign stop_ev  = scl_i && scl_r && !sda_r && sda_i;

  // Pin history, clock-low time, cycles since stop
  always_ff @(posedge ref_clk_i) begin
    scl_r  <= sys_rst_i | scl_i;
    sda_r  <= sys_rst_i | sda_i;
    low_r  <= (sys_rst_i || scl_i) ? 5'h00 : low_r + 5'(low_r != 5'h1f);
    stop_r <= stop_ev ? 5'h00 : (sys_rst_i ? 5'h1f : stop_r + 5'(stop_r != 5'h1f));
  end

  // Clock rises in the frame and direction of the first byte
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || start_ev || stop_ev) begin
      bit_r   <= 4'h0;
      first_r <= 1'b1;
      rd_r    <= 1'b0;
    end else if (scl_i && !scl_r) begin
      bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
      if (bit_r == 4'h7 && first_r) rd_r <= sda_i;
      if (bit_r == 4'h8) first_r <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  rst_idle_a: assert property (disable iff (1'b0)
    sys_rst_i |=> standby_o && !sda_oe_o && !wr_valid_o && !rd_ready_o)
    else $error("outputs not idle after reset");
  oe_rise_a: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("data drive began with clock high");
  oe_hold_a: assert property (($changed(sda_oe_o) && !scl_i) |-> low_r >= 5'h14)
    else $error("data drive changed too soon after clock fall");
  ack_ninth_a: assert property ((scl_i && !scl_r && sda_oe_o && !rd_r) |-> bit_r == 4'h8)
    else $error("write side pull outside ninth clock");
  busy_nack_a: assert property ((wr_busy_i && $past(wr_busy_i, 8)) |-> !$rose(sda_oe_o))
    else $error("acknowledge while write cycle runs");
  busy_sby_a: assert property (wr_busy_i |=> !standby_o)
    else $error("standby during write cycle");
  wcyc_stop_a: assert property (wcyc_start_o |-> stop_r <= 5'h0c ##1 !wcyc_start_o)
    else $error("write cycle start not a pulse after stop");
  start_clr_a: assert property (start_ev |-> ##[1:8] !sda_oe_o)
    else $error("data drive kept after start");
  stop_sby_a: assert property (stop_ev |-> ##[1:12] (standby_o || wr_busy_i))
    else $error("no standby after stop");
  buf_hold_a: assert property ((wr_valid_o && !wr_ready_i) |=> wr_valid_o && $stable(wr_data_o))
    else $error("buffered word dropped while stalled");

  cover property (rd_valid_i && rd_ready_o);
  cover property (wr_valid_o && !wr_ready_i ##1 wr_valid_o);
  cover property (wcyc_start_o);
endmodule

bind see_eeprom_client see_chk u_chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_bit2_i(chip_select_bit2_i),
  .chip_select_bit1_i(chip_select_bit1_i), .chip_select_bit0_i(chip_select_bit0_i),
  .wr_busy_i(wr_busy_i), .wcyc_start_o(wcyc_start_o), .standby_o(standby_o),
  .word_addr_o(word_addr_o), .area_o(area_o), .wr_valid_o(wr_valid_o),
  .wr_ready_i(wr_ready_i), .wr_data_o(wr_data_o), .wr_addr_o(wr_addr_o),
  .wr_area_o(wr_area_o), .rd_ready_o(rd_ready_o), .rd_valid_i(rd_valid_i),
  .rd_data_i(rd_data_i));

// *** sim/see_host.sv ***
`timescale 1ns/1ps
module see_host (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  localparam int QTR = 20;

  // Bus idle: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Wait a number of quarter bit times
  task automatic wq(input int n);
    repeat (n * QTR) @(negedge ref_clk_i);
  endtask

  // One bit: data set while clock low, sampled in mid high
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = ~b;
    wq(2);
    scl_o = 1'b1;
    wq(1);
    r = sda_i;
    wq(1);
    scl_o = 1'b0;
  endtask

  // Start or repeated start, clearing a stuck data line first
  task automatic start();
    sda_oe_o = 1'b0;
    wq(2);
    scl_o = 1'b1;
    wq(1);
    for (int i = 0; i < 9 && !sda_i; i++) begin
      scl_o = 1'b0;
      wq(2);
      scl_o = 1'b1;
      wq(2);
    end
    sda_oe_o = 1'b1;
    wq(1);
    scl_o = 1'b0;
  endtask

  // Eight bits msb first, then the ninth clock
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, ack);
  endtask

  // Stop: data rises while clock high
  task automatic stop();
    sda_oe_o = 1'b1;
    wq(2);
    scl_o = 1'b1;
    wq(1);
    sda_oe_o = 1'b0;
    wq(4);
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb import see_pkg::*;;
  logic                  ref_clk_i, sys_rst_i, scl, sda, sda_o, dut_oe, host_oe, ack, stall;
  logic                  wr_busy_i, wcyc_start_o, standby_o, wr_valid_o, wr_ready_i, took;
  logic                  rd_ready_o, rd_valid_i;
  logic [2:0]            cs;
  logic [SEE_ADDR_W-1:0] word_addr_o, wr_addr_o;
  see_area_type          area_o, wr_area_o;
  logic [7:0]            wr_data_o, rd_data_i, rx;
  logic [7:0]            bad_dev [3];
  logic [15:0]           wexp [$];
  logic [7:0]            rq [$];
  int                    bad_count, comparisons, wcyc_cnt, busy_left;
  see_area_type          ars [3] = '{SEE_AREA_MAIN, SEE_AREA_SEC, SEE_AREA_LOCK};
  logic [15:0]           ads [3] = '{16'hd5bf, 16'hf9c5, 16'h0440};
  logic [3:0]            cds [3] = '{4'ha, 4'hb, 4'hb};

  see_eeprom_client u_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(dut_oe), .chip_select_bit2_i(cs[2]),
    .chip_select_bit1_i(cs[1]), .chip_select_bit0_i(cs[0]), .wr_busy_i(wr_busy_i),
    .wcyc_start_o(wcyc_start_o), .standby_o(standby_o), .word_addr_o(word_addr_o),
    .area_o(area_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .wr_data_o(wr_data_o), .wr_addr_o(wr_addr_o), .wr_area_o(wr_area_o),
    .rd_ready_o(rd_ready_o), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i));
  see_host u_host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

  // Open-drain data line with pull-up
  assign sda = !((dut_oe && !sda_o) || host_oe);

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Host sends a byte and checks the ninth-clock level
  task automatic put(input logic [7:0] b, input logic e);
    u_host.xfer(b, 1'b1, rx, ack);
    chk("ack", 24'(e), 24'(ack));
  endtask

  // Address phase, area decode, then n data words
  task automatic wr_seq(input logic [3:0] cd, input logic [15:0] ad, input see_area_type ar,
                        input int n);
    logic [14:0] ea;
    logic [7:0]  d;
    ea = (ar == SEE_AREA_MAIN) ? ad[14:0] : (ar == SEE_AREA_SEC) ? {9'h0, ad[5:0]} :
         (ar == SEE_AREA_UID) ? {11'h0, ad[3:0]} : 15'h0;
    u_host.start();
    put({cd, cs, 1'b0}, 1'b0);
    put(ad[15:8], 1'b0);
    put(ad[7:0], 1'b0);
    chk("area", 24'(ar), 24'(area_o));
    chk("word addr", 24'(ea), 24'(word_addr_o));
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      wexp.push_back({ar, ad[5:0] + 6'(i), d});
      put(d, 1'b0);
    end
  endtask

  // Let the write cycle run out
  task automatic idle_wait();
    for (int k = 0; k < 3000 && wr_busy_i; k++) @(negedge ref_clk_i);
    repeat (8) @(negedge ref_clk_i);
    chk("standby", 24'h1, 24'(standby_o));
  endtask

  // Result monitor: words, read handshakes, write cycle starts
  always @(posedge ref_clk_i) begin
    if (wr_valid_o === 1'b1 && wr_ready_i) begin
      if (wexp.size() == 0) chk("extra word", 24'h0, 24'h1);
      else chk("word", 24'(wexp.pop_front()), 24'({wr_area_o, wr_addr_o[5:0], wr_data_o}));
    end
    if (rd_valid_i && rd_ready_o === 1'b1) begin
      rq.push_back(rd_data_i);
      took = 1'b1;
    end
    if (wcyc_start_o === 1'b1) begin
      wcyc_cnt++;
      busy_left = 1500;
    end
  end

  // Consumer, read source and write-cycle busy
  always @(negedge ref_clk_i) begin
    wr_ready_i <= stall ? 1'b0 : 1'($urandom);
    if (took) rd_data_i <= 8'($urandom);
    took = 1'b0;
    if (busy_left > 0) busy_left--;
    wr_busy_i <= (busy_left > 0);
  end

  initial begin
    repeat (80000) @(posedge ref_clk_i);
    bad_count++;
    close_out();
  end

  initial begin
    sys_rst_i = 1'b1;
    cs = 3'h0;
    wr_busy_i = 1'b0;
    wr_ready_i = 1'b0;
    rd_valid_i = 1'b0;
    rd_data_i = 8'h00;
    stall = 1'b0;
    took = 1'b0;
    busy_left = 0;
    void'($urandom(32'hf9f7));
    @(negedge ref_clk_i);
    cs = 3'($urandom);
    rd_valid_i = 1'b1;
    bad_dev = '{{4'ha, ~cs, 1'b0}, {4'hc, cs, 1'b0}, 8'h09};
    repeat (11) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    chk("reset", 24'h200000, 24'({standby_o, dut_oe, wr_valid_o, rd_ready_o, wcyc_start_o,
        area_o, word_addr_o}));
    repeat (3) @(negedge ref_clk_i);
    $display("test reset done");
    for (int t = 0; t < 3; t++) begin
      wr_seq(cds[t], ads[t], ars[t], (t == 2) ? 1 : 2);
      u_host.stop();
      chk("write cycles", 24'(t + 1), 24'(wcyc_cnt));
      u_host.start();
      put({4'ha, cs, 1'b0}, 1'b1);
      u_host.stop();
      idle_wait();
    end
    $display("test area writes done");
    foreach (bad_dev[i]) begin
      u_host.start();
      put(bad_dev[i], 1'b1);
      put(8'h00, 1'b1);
      chk("standby", 24'h1, 24'(standby_o));
      u_host.stop();
    end
    $display("test address refusal done");
    wr_seq(4'ha, 16'h0123, SEE_AREA_MAIN, 1);
    for (int i = 0; i < 4; i++) u_host.bit_io(1'b0, ack);
    u_host.stop();
    chk("write cycles", 24'h3, 24'(wcyc_cnt));
    idle_wait();
    $display("test abort done");
    stall = 1'b1;
    wr_seq(4'ha, 16'h0a10, SEE_AREA_MAIN, 2);
    put(8'h5a, 1'b1);
    stall = 1'b0;
    for (int k = 0; k < 200 && wexp.size() > 0; k++) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("drained", 24'h0, 24'(wr_valid_o));
    u_host.stop();
    chk("write cycles", 24'h4, 24'(wcyc_cnt));
    idle_wait();
    $display("test buffer full done");
    wr_seq(4'hb, 16'h3a7c, SEE_AREA_UID, 0);
    u_host.start();
    put({4'hb, cs, 1'b1}, 1'b0);
    for (int i = 0; i < 2; i++) begin
      u_host.xfer(8'hff, 1'(i == 1), rx, ack);
      chk("read byte", 24'(rq.size() > 0 ? rq.pop_front() : 8'hxx), 24'(rx));
    end
    u_host.stop();
    repeat (12) @(negedge ref_clk_i);
    chk("standby", 24'h1, 24'(standby_o));
    $display("test read done");
    close_out();
  end
endmodule
